/* rtl/watchdog_pkg.sv */
// constants, state codes and helpers for the two-stage watchdog
// assumes a single 100 MHz clock and a synchronous active-low reset
package watchdog_pkg;

  // -------------------------------------------------------------
  // clock and timebase
  // -------------------------------------------------------------
  localparam int CNT_W = 35;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;

  // -------------------------------------------------------------
  // timeout range, in timebase ticks
  // -------------------------------------------------------------
  localparam int MIN_TIMEOUT_MS = 1;
  localparam int MAX_TIMEOUT_MIN = 10;
  localparam logic [CNT_W-1:0] MIN_TICKS =
    CNT_W'(longint'(MIN_TIMEOUT_MS) * 64'd1000000 / longint'(TICK_NS));
  localparam logic [CNT_W-1:0] MAX_TICKS =
    CNT_W'(longint'(MAX_TIMEOUT_MIN) * 64'd60000000000 / longint'(TICK_NS));
  localparam logic [CNT_W-1:0] CNT_ONE = 35'h000000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 35'h000000000;

  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FIRST = 4'b0010,
    ST_SECOND = 4'b0100,
    ST_RESET = 4'b1000
  } wdState_t;

  typedef enum logic [1:0] {
    KIND_IRQ = 2'h0,
    KIND_SMI = 2'h1,
    KIND_SCI = 2'h2,
    KIND_SPARE = 2'h3
  } intKind_t;

  // keep a preload inside the supported timeout range
  function automatic logic [CNT_W-1:0] clampTimeout(input logic [CNT_W-1:0] val);
    logic [CNT_W-1:0] res;
    res = val;
    if (val < MIN_TICKS) begin
      res = MIN_TICKS;
    end else if (val > MAX_TICKS) begin
      res = MAX_TICKS;
    end
    return res;
  endfunction : clampTimeout

endpackage : watchdog_pkg

/* rtl/two_stage_watchdog.sv */
// two-stage watchdog: first expiry raises an interrupt, second a system reset
// assumes host strobes are synchronous one-cycle pulses on the same clock
`timescale 1ns/1ns

module two_stage_watchdog (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic reloadPulse,
  input wire logic [watchdog_pkg::CNT_W-1:0] firstPreload,
  input wire logic [watchdog_pkg::CNT_W-1:0] secondPreload,
  input wire watchdog_pkg::intKind_t intKind,
  output logic irqOut,
  output logic system_management_interrupt,
  output logic power_mgmt_control_interrupt,
  output logic sysResetOut,
  output logic secondStage,
  output logic [watchdog_pkg::CNT_W-1:0] countValue
);
  import watchdog_pkg::*;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  wdState_t state_r, state_nxt;
  logic [CNT_W-1:0] count_r, count_nxt;
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic irq_r, irq_nxt;
  logic smi_r, smi_nxt;
  logic sci_r, sci_nxt;
  logic rst_r, rst_nxt;
  logic tick;
  logic expire;

  // timebase tick every microsecond so 35 bits reach ten minutes
  assign tick = (pre_r == PRE_LAST);
  assign expire = tick && (count_r == CNT_ONE);

  // -------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    pre_nxt = (tick) ? PRE_ZERO : pre_r + 7'h01;
    irq_nxt = 1'b0;
    smi_nxt = 1'b0;
    sci_nxt = 1'b0;
    rst_nxt = rst_r;
    unique case (state_r)
      ST_IDLE: begin
        // prescaler held at zero so the first tick is a full period after the load
        pre_nxt = PRE_ZERO;
        count_nxt = CNT_ZERO;
        if (enable) begin
          state_nxt = ST_FIRST;
          count_nxt = clampTimeout(firstPreload);
        end
      end
      ST_FIRST, ST_SECOND: begin
        // dropping enable abandons the sequence; nothing is signalled
        if (!enable) begin
          state_nxt = ST_IDLE;
          count_nxt = CNT_ZERO;
          pre_nxt = PRE_ZERO;
        end else if (reloadPulse) begin
          // reload wins over a coincident expiry, so a late refresh still saves it
          state_nxt = ST_FIRST;
          count_nxt = clampTimeout(firstPreload);
          pre_nxt = PRE_ZERO;
        end else if (expire && state_r == ST_FIRST) begin
          // stage one ran out: pick the interrupt line and start stage two
          state_nxt = ST_SECOND;
          count_nxt = clampTimeout(secondPreload);
          irq_nxt = (intKind == KIND_IRQ) || (intKind == KIND_SPARE);
          smi_nxt = (intKind == KIND_SMI);
          sci_nxt = (intKind == KIND_SCI);
        end else if (expire) begin
          // stage two ran out: latch the reset until rst_n comes back
          state_nxt = ST_RESET;
          rst_nxt = 1'b1;
        end else if (tick) begin
          count_nxt = count_r - CNT_ONE;
        end
      end
      ST_RESET: begin
        // held until the system reset comes back around as rst_n
        rst_nxt = 1'b1;
        pre_nxt = PRE_ZERO;
      end
      default: begin
        state_nxt = ST_IDLE;
        count_nxt = CNT_ZERO;
        pre_nxt = PRE_ZERO;
      end
    endcase
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  // plain registers; rst_n is sampled on the edge, never asynchronous
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      count_r <= CNT_ZERO;
      pre_r <= PRE_ZERO;
      irq_r <= 1'b0;
      smi_r <= 1'b0;
      sci_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      pre_r <= pre_nxt;
      irq_r <= irq_nxt;
      smi_r <= smi_nxt;
      sci_r <= sci_nxt;
      rst_r <= rst_nxt;
    end
  end

  // outputs come straight from the state registers
  assign irqOut = irq_r;
  assign system_management_interrupt = smi_r;
  assign power_mgmt_control_interrupt = sci_r;
  assign sysResetOut = rst_r;
  assign secondStage = state_r[2];
  assign countValue = count_r;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  // any one of the three interrupt pulses
  logic anyInt;
  assign anyInt = irq_r || smi_r || sci_r;

  AST_START_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_IDLE && enable |=> state_r == ST_FIRST
      && count_r == clampTimeout($past(firstPreload)))
    else $error("first stage did not load first preload");

  AST_DECREMENT: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == ST_FIRST || state_r == ST_SECOND) && enable && !reloadPulse
      && tick && !expire |=> count_r == $past(count_r) - CNT_ONE)
    else $error("counter did not decrement on tick");

  AST_FIRST_EXPIRE_INT: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_FIRST && enable && !reloadPulse && expire |=> anyInt && secondStage)
    else $error("first expiry raised no interrupt");

  AST_INT_KIND: assert property (@(posedge clock) disable iff (!rst_n)
    anyInt |-> $onehot({irq_r, smi_r, sci_r})
      && (smi_r == ($past(intKind) == KIND_SMI))
      && (sci_r == ($past(intKind) == KIND_SCI)))
    else $error("interrupt kind does not match selection");

  AST_SECOND_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    anyInt |-> state_r == ST_SECOND && count_r == clampTimeout($past(secondPreload)))
    else $error("second preload not loaded after interrupt");

  AST_RESET_OUT: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_SECOND && enable && !reloadPulse && expire
      |=> sysResetOut ##1 sysResetOut)
    else $error("second expiry did not assert reset");

  AST_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(state_r) && state_r != ST_IDLE && state_r != ST_RESET
      |-> count_r >= MIN_TICKS && count_r <= MAX_TICKS)
    else $error("loaded timeout out of range");

  AST_RELOAD: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == ST_FIRST || state_r == ST_SECOND) && enable && reloadPulse
      |=> state_r == ST_FIRST && count_r == clampTimeout($past(firstPreload)) && !anyInt)
    else $error("reload did not restart stage one");

  // interrupts are single-cycle pulses; a stuck line would look like repeated expiries
  AST_INT_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
    anyInt |=> !anyInt)
    else $error("interrupt lasted more than one cycle");

  // an interrupt may only follow a stage-one expiry that no reload cancelled
  AST_INT_CAUSE: assert property (@(posedge clock) disable iff (!rst_n)
    anyInt |-> $past(state_r) == ST_FIRST && $past(expire) && !$past(reloadPulse))
    else $error("interrupt raised without a stage-one expiry");

  // the reset line is never raised outside the terminal state
  AST_RESET_STATE: assert property (@(posedge clock) disable iff (!rst_n)
    sysResetOut |-> state_r == ST_RESET)
    else $error("system reset asserted outside reset state");

  // once in reset only rst_n may leave it, whatever enable does
  AST_RESET_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_RESET |=> state_r == ST_RESET && sysResetOut)
    else $error("system reset state left without rst_n");

  // between ticks the count must stand still, or timeouts would run short
  AST_COUNT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == ST_FIRST || state_r == ST_SECOND) && enable && !reloadPulse && !tick
      |=> $stable(count_r))
    else $error("counter moved between ticks");

  // main scenarios the bench is expected to reach
  COV_FIRST_EXPIRE: cover property (@(posedge clock) disable iff (!rst_n) anyInt);
  COV_SMI: cover property (@(posedge clock) disable iff (!rst_n) smi_r);
  COV_SCI: cover property (@(posedge clock) disable iff (!rst_n) sci_r);
  COV_RESET: cover property (@(posedge clock) disable iff (!rst_n) $rose(sysResetOut));
  COV_RELOAD_SECOND: cover property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_SECOND && reloadPulse && enable);

endmodule : two_stage_watchdog

/* verification/host_model.sv */
// host software stand-in that refreshes the watchdog
// assumes the bench clock; alive low models a hung application
`timescale 1ns/1ns
module host_model #(
  parameter int PERIOD = 50
) (
  input wire logic clock,
  input wire logic alive,
  output logic reloadPulse
);
  int cnt = 0;
  logic pulse_r = 1'b0;
  // one-cycle refresh far inside the timeout; a hung host simply stops
  always @(posedge clock) begin
    cnt <= (alive && cnt < PERIOD - 1) ? cnt + 1 : 0;
    pulse_r <= alive && cnt == PERIOD - 1;
  end
  assign reloadPulse = pulse_r;
endmodule : host_model

/* verification/two_stage_watchdog_bench.sv */
// self-checking bench for the two-stage watchdog
// assumes the watchdog package is compiled first; a stage lasts 100k clocks
`timescale 1ns/1ns
module two_stage_watchdog_bench;
  import watchdog_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, enable = 1'b0, alive = 1'b0;
  logic reloadPulse, irqOut, smiOut, sciOut, sysResetOut, secondStage;
  logic [CNT_W-1:0] firstPreload = '1, secondPreload = '0, countValue;
  intKind_t intKind = KIND_IRQ;
  int errors = 0, tests_run = 0, seed = 27263, s, k, c;
  logic [CNT_W-1:0] inRange;
  wire [4:0] flags = {irqOut, smiOut, sciOut, secondStage, sysResetOut};
  two_stage_watchdog two_stage_watchdog_i (.clock(clock), .rst_n(rst_n), .enable(enable),
    .reloadPulse(reloadPulse), .firstPreload(firstPreload), .secondPreload(secondPreload),
    .intKind(intKind), .irqOut(irqOut), .system_management_interrupt(smiOut),
    .power_mgmt_control_interrupt(sciOut), .sysResetOut(sysResetOut),
    .secondStage(secondStage), .countValue(countValue));
  host_model host_model_i (.clock(clock), .alive(alive), .reloadPulse(reloadPulse));
  initial forever #5 clock = ~clock;
  // reference clamp in microsecond ticks
  function automatic longint refClamp(input longint v);
    longint lo = MIN_TIMEOUT_MS * 1000;
    longint hi = longint'(MAX_TIMEOUT_MIN) * 60000000;
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction : refClamp
  task automatic checkVal(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: value %0h expected %0h", $time, got, exp);
    end
  endtask : checkVal
  task automatic checkFlags(input logic [4:0] got, input logic [4:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: outputs %b expected %b", $time, got, exp);
    end
  endtask : checkFlags
  // bounded wait for an interrupt pulse or the reset level
  task automatic waitFor(input bit rstEvt, output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while ((rstEvt ? sysResetOut !== 1'b1 : !(irqOut | smiOut | sciOut)) && n < 100200);
  endtask : waitFor
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    // five stages of 100k clocks plus margin
    repeat (700000) @(posedge clock);
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    enable <= 1'b1;
    @(posedge clock);
    #1;
    checkVal(countValue, CNT_W'(refClamp(longint'(firstPreload))));
    repeat (150) @(posedge clock);
    #1;
    checkVal(countValue, CNT_W'(refClamp(longint'(firstPreload)) - 1));
    $display("load and count test done");
    @(posedge clock);
    s = $unsigned($random(seed)) % 4;
    inRange = CNT_W'(refClamp(0) + $unsigned($random(seed)) % 100000);
    firstPreload <= inRange;
    secondPreload <= CNT_W'($unsigned($random(seed)) % 1000);
    alive <= 1'b1;
    // an in-range preload must load unchanged on a refresh
    @(posedge clock iff reloadPulse);
    firstPreload <= CNT_W'($unsigned($random(seed)) % 1000);
    #1;
    checkVal(countValue, CNT_W'(refClamp(longint'(inRange))));
    $display("in-range load test done");
    // every loop starts from a fresh refresh edge; short preloads clamp up
    for (int i = 0; i < 4; i++) begin
      @(posedge clock iff reloadPulse);
      alive <= 1'b0;
      k = (s + i) % 4;
      intKind <= intKind_t'(k);
      #1;
      checkVal(countValue, CNT_W'(refClamp(0)));
      checkFlags(flags, 5'b00000);
      waitFor(1'b0, c);
      checkVal(CNT_W'(c), CNT_W'(refClamp(0) * TICK_CYC));
      checkFlags(flags, {k == 0 || k == 3, k == 1, k == 2, 2'b10});
      checkVal(countValue, CNT_W'(refClamp(0)));
      @(posedge clock);
      alive <= (i < 3);
      #1;
      checkFlags(flags, 5'b00010);
      $display("expiry test %0d done", i);
    end
    waitFor(1'b1, c);
    checkVal(CNT_W'(c + 1), CNT_W'(refClamp(0) * TICK_CYC));
    @(posedge clock);
    enable <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
    checkVal(CNT_W'(sysResetOut), 35'd1);
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    #1;
    checkFlags(flags, 5'b00000);
    checkVal(countValue, CNT_W'(0));
    $display("system reset test done");
    report_and_stop();
  end
endmodule : two_stage_watchdog_bench
